// file: shared/slb_pkg.sv
package slb_pkg;

  // ---------------------------------------------------------------
  // Limits and reset values
  // ---------------------------------------------------------------
  localparam int   MIN_INPUTS    = 2;
  localparam int   MAX_INPUTS    = 5;
  localparam logic LATCH_RST_VAL = 1'b0;

  // ---------------------------------------------------------------
  // Source select codes
  // ---------------------------------------------------------------
  localparam logic [1:0] SRC_SAFE_IN   = 2'h0;
  localparam logic [1:0] SRC_PLAIN_IN  = 2'h1;
  localparam logic [1:0] SRC_SAFE_OUT  = 2'h2;
  localparam logic [1:0] SRC_BLOCK_OUT = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SLB_AND,
    SLB_OR,
    SLB_NAND,
    SLB_NOR,
    SLB_XOR,
    SLB_NOT,
    SLB_RS_LATCH,
    SLB_SR_LATCH
  } slb_func_t;

  typedef struct packed {
    slb_func_t  func;
    logic [2:0] n_inputs;
    logic [4:0] inv_src;
    logic       inv_out;
  } slb_cfg_t;

  typedef struct packed {
    logic ch_a;
    logic ch_b;
  } slb_dual_t;

endpackage

// file: hw/slb_logic_block.sv
// Operation
// - Signals encode On=1, Off=0; output follows inputs
// - Inputs from safety, plain, outputs or blocks
// - AND of 2-5 inputs
// - OR of 2-5 inputs
// - NAND of 2-5 inputs
// - NOR of 2-5 inputs
// - XOR: On only when exactly one On
// - NOT complements its single input
// - Reset-dominant latch clears when both high
// - Set-dominant latch sets when both high
// - Inverted source treats Stop as True
// - Inverted output turns Off when function True
// - Dual-channel Run: both high or complementary
`timescale 1ns/1ps
module slb_logic_block #(
  parameter int N_SRC = 4
) (
  input  wire logic                     clk_in,
  input  wire logic                     resetn_in,
  input  wire slb_pkg::slb_cfg_t        cfg_in,
  input  wire logic [4:0][1:0]          src_type_in,
  input  wire logic [4:0][N_SRC-1:0]    src_idx_in,
  input  wire slb_pkg::slb_dual_t [N_SRC-1:0] safe_in,
  input  wire logic [N_SRC-1:0]         safe_cmpl_in,
  input  wire logic [N_SRC-1:0]         plain_in,
  input  wire logic [N_SRC-1:0]         safe_out_in,
  input  wire logic [N_SRC-1:0]         block_out_in,
  output logic                          result_out
);

  // ---------------------------------------------------------------
  // Parameter check
  // ---------------------------------------------------------------
  // Source indices reach the selector as a 32-bit int
  if (N_SRC < 1 || N_SRC > 32) begin : g_bad_n_src
    $error("N_SRC out of range");
  end

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  // Pins are asynchronous to the scan clock; only stage two is read
  slb_pkg::slb_dual_t [N_SRC-1:0] safe_s1_q;
  slb_pkg::slb_dual_t [N_SRC-1:0] safe_s2_q;
  logic [N_SRC-1:0]               plain_s1_q;
  logic [N_SRC-1:0]               plain_s2_q;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      safe_s1_q  <= '0;
      safe_s2_q  <= '0;
      plain_s1_q <= '0;
      plain_s2_q <= '0;
    end else begin
      safe_s1_q  <= safe_in;
      safe_s2_q  <= safe_s1_q;
      plain_s1_q <= plain_in;
      plain_s2_q <= plain_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // Dual-channel Run decode
  // ---------------------------------------------------------------
  // Any channel pair other than the Run pattern reads as Stop
  function automatic logic run_state(input slb_pkg::slb_dual_t d,
                                     input logic cmpl);
    run_state = cmpl ? (d.ch_a & ~d.ch_b) : (d.ch_a & d.ch_b);
  endfunction

  logic [N_SRC-1:0] safe_run;
  always_comb begin
    for (int i = 0; i < N_SRC; i++) begin
      safe_run[i] = run_state(safe_s2_q[i], safe_cmpl_in[i]);
    end
  end

  for (genvar g = 0; g < N_SRC; g++) begin : g_run_chk
    AST_RUN_BOTH: assert property (@(posedge clk_in)
      !safe_cmpl_in[g] && safe_s2_q[g].ch_a && safe_s2_q[g].ch_b
      |-> safe_run[g])
      else $error("Both-high Run not recognised");
    AST_RUN_CMPL: assert property (@(posedge clk_in)
      safe_cmpl_in[g] && safe_s2_q[g].ch_a && !safe_s2_q[g].ch_b
      |-> safe_run[g])
      else $error("Complementary Run not recognised");
    AST_RUN_STOP: assert property (@(posedge clk_in)
      !safe_s2_q[g].ch_a
      |-> !safe_run[g])
      else $error("Channel A low read as Run");
  end

  // ---------------------------------------------------------------
  // Input selection and inversion
  // ---------------------------------------------------------------
  function automatic logic pick(input logic [1:0] typ,
                                input int unsigned idx,
                                input logic [N_SRC-1:0] a,
                                input logic [N_SRC-1:0] b,
                                input logic [N_SRC-1:0] c,
                                input logic [N_SRC-1:0] d);
    logic v;
    v = 1'b0;
    if (idx < N_SRC) begin
      unique case (typ)
        slb_pkg::SRC_SAFE_IN:   v = a[idx];
        slb_pkg::SRC_PLAIN_IN:  v = b[idx];
        slb_pkg::SRC_SAFE_OUT:  v = c[idx];
        slb_pkg::SRC_BLOCK_OUT: v = d[idx];
      endcase
    end
    pick = v;
  endfunction

  logic [4:0] in_raw;
  logic [4:0] in_used;
  logic [4:0] in_val;
  logic [2:0] n_act;
  logic [2:0] ones;

  assign n_act = (cfg_in.func == slb_pkg::SLB_NOT) ? 3'h1 :
                 (cfg_in.func == slb_pkg::SLB_RS_LATCH ||
                  cfg_in.func == slb_pkg::SLB_SR_LATCH) ? 3'h2 :
                 (cfg_in.n_inputs < 3'(slb_pkg::MIN_INPUTS)) ? 3'h2 :
                 (cfg_in.n_inputs > 3'(slb_pkg::MAX_INPUTS)) ? 3'h5 :
                 cfg_in.n_inputs;

  // Unused lanes are masked so their sources cannot sway the result
  always_comb begin
    ones = 3'h0;
    for (int i = 0; i < slb_pkg::MAX_INPUTS; i++) begin
      in_raw[i]  = pick(src_type_in[i], int'(src_idx_in[i]), safe_run,
                        plain_s2_q, safe_out_in, block_out_in);
      in_val[i]  = in_raw[i] ^ cfg_in.inv_src[i];
      in_used[i] = (3'(i) < n_act);
      if (in_used[i] && in_val[i])
        ones = ones + 3'h1;
    end
  end

  AST_LANES: assert property (@(posedge clk_in)
    cfg_in.func inside {slb_pkg::SLB_AND, slb_pkg::SLB_OR,
                        slb_pkg::SLB_NAND, slb_pkg::SLB_NOR,
                        slb_pkg::SLB_XOR}
    |-> n_act >= 3'(slb_pkg::MIN_INPUTS) &&
        n_act <= 3'(slb_pkg::MAX_INPUTS))
    else $error("Active lane count out of range");
  AST_SRC_RANGE: assert property (@(posedge clk_in)
    int'(src_idx_in[0]) >= N_SRC
    |-> !in_raw[0])
    else $error("Out-of-range source not read as Off");
  AST_INV_SRC: assert property (@(posedge clk_in)
    cfg_in.inv_src[0] && !in_raw[0]
    |-> in_val[0])
    else $error("Inverted Stop source not read as True");

  // ---------------------------------------------------------------
  // Gate functions
  // ---------------------------------------------------------------
  wire all_on = &(in_val | ~in_used);
  wire any_on = |(in_val & in_used);
  wire one_on = (ones == 3'h1);
  wire set_w  = in_val[0];
  wire rst_w  = in_val[1];

  logic latch_q;
  logic latch_d;
  logic func_val;

  // Latch state holds while another function is selected
  always_comb begin
    latch_d = latch_q;
    if (cfg_in.func == slb_pkg::SLB_RS_LATCH) begin
      if (rst_w)
        latch_d = 1'b0;
      else if (set_w)
        latch_d = 1'b1;
    end else if (cfg_in.func == slb_pkg::SLB_SR_LATCH) begin
      if (set_w)
        latch_d = 1'b1;
      else if (rst_w)
        latch_d = 1'b0;
    end
  end

  always_comb begin
    unique case (cfg_in.func)
      slb_pkg::SLB_AND:      func_val = all_on;
      slb_pkg::SLB_OR:       func_val = any_on;
      slb_pkg::SLB_NAND:     func_val = ~all_on;
      slb_pkg::SLB_NOR:      func_val = ~any_on;
      slb_pkg::SLB_XOR:      func_val = one_on;
      slb_pkg::SLB_NOT:      func_val = ~in_val[0];
      slb_pkg::SLB_RS_LATCH: func_val = latch_d;
      slb_pkg::SLB_SR_LATCH: func_val = latch_d;
      default:               func_val = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // State and output
  // ---------------------------------------------------------------
  // Inverted options are honoured but are hazardous in safety use
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      latch_q    <= slb_pkg::LATCH_RST_VAL;
      result_out <= 1'b0;
    end else begin
      latch_q    <= latch_d;
      result_out <= func_val ^ cfg_in.inv_out;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  AST_AND: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_AND && !cfg_in.inv_out
    |=> result_out == $past(all_on))
    else $error("AND output wrong");
  AST_OR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_OR && !cfg_in.inv_out
    |=> result_out == $past(any_on))
    else $error("OR output wrong");
  AST_NAND: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_NAND && !cfg_in.inv_out && all_on
    |=> !result_out)
    else $error("NAND output wrong");
  AST_NOR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_NOR && !cfg_in.inv_out && any_on
    |=> !result_out)
    else $error("NOR output wrong");
  AST_XOR: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_XOR && !cfg_in.inv_out
    |=> result_out == ($past(ones) == 3'h1))
    else $error("XOR output wrong");
  AST_NOT: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_NOT && !cfg_in.inv_out
    |=> result_out != $past(in_val[0]))
    else $error("NOT output wrong");
  AST_RSL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_RS_LATCH && rst_w |=> !latch_q)
    else $error("Reset-dominant latch not cleared");
  AST_SRL: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_SR_LATCH && set_w |=> latch_q)
    else $error("Set-dominant latch not set");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (cfg_in.func == slb_pkg::SLB_RS_LATCH ||
     cfg_in.func == slb_pkg::SLB_SR_LATCH) && !set_w && !rst_w
    |=> $stable(latch_q))
    else $error("Latch did not hold");
  AST_INV: assert property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.inv_out |=> result_out == !$past(func_val))
    else $error("Output inversion wrong");
  AST_NAND_ON: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_NAND && !cfg_in.inv_out && !all_on
    |=> result_out)
    else $error("NAND output not On");
  AST_NOR_ON: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_NOR && !cfg_in.inv_out && !any_on
    |=> result_out)
    else $error("NOR output not On");
  AST_RSL_SET: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_RS_LATCH && set_w && !rst_w
    |=> latch_q)
    else $error("Reset-dominant latch not set");
  AST_SRL_CLR: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_SR_LATCH && rst_w && !set_w
    |=> !latch_q)
    else $error("Set-dominant latch not cleared");
  AST_LATCH_OUT: assert property (@(posedge clk_in)
    disable iff (!resetn_in)
    (cfg_in.func == slb_pkg::SLB_RS_LATCH ||
     cfg_in.func == slb_pkg::SLB_SR_LATCH) && !cfg_in.inv_out
    |=> result_out == latch_q)
    else $error("Latch output differs from state");
  AST_RESET: assert property (@(posedge clk_in)
    !resetn_in && !$past(resetn_in)
    |-> !result_out && !latch_q)
    else $error("Outputs not cleared in reset");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  COV_XOR1: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_XOR && ones == 3'h1);
  COV_BOTH: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_RS_LATCH && set_w && rst_w);
  COV_INV: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.inv_src != 5'h00 && result_out);
  COV_SR_BOTH: cover property (@(posedge clk_in) disable iff (!resetn_in)
    cfg_in.func == slb_pkg::SLB_SR_LATCH && set_w && rst_w);
  COV_RUN_CMPL: cover property (@(posedge clk_in) disable iff (!resetn_in)
    |(safe_run & safe_cmpl_in));

endmodule

// file: test/slb_logic_block_tb.sv
`timescale 1ns/1ps
module slb_logic_block_tb;
  localparam int NS = 8;
  logic                        clk_in;
  logic                        resetn_in;
  slb_pkg::slb_cfg_t           cfg_in;
  logic [4:0][1:0]             src_type_in;
  logic [4:0][NS-1:0]          src_idx_in;
  slb_pkg::slb_dual_t [NS-1:0] safe_in;
  logic [NS-1:0]               safe_cmpl_in;
  logic [NS-1:0]               plain_in;
  logic [NS-1:0]               safe_out_in;
  logic [NS-1:0]               block_out_in;
  logic                        result_out;
  int                          err_total;
  int                          samples_checked;

  slb_logic_block #(.N_SRC(NS)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .cfg_in(cfg_in),
    .src_type_in(src_type_in), .src_idx_in(src_idx_in),
    .safe_in(safe_in), .safe_cmpl_in(safe_cmpl_in),
    .plain_in(plain_in), .safe_out_in(safe_out_in),
    .block_out_in(block_out_in), .result_out(result_out));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %b seen %b", what, e, g);
    end
  endtask

  // Inputs change at the falling edge, result is read at the next falling edge
  task automatic step;
    @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic set_cfg(input int f, input int n, input logic [4:0] iv,
                         input logic io);
    cfg_in.func     = slb_pkg::slb_func_t'(f);
    cfg_in.n_inputs = 3'(n);
    cfg_in.inv_src  = iv;
    cfg_in.inv_out  = io;
  endtask

  task automatic results;
    $display("errors %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Every gate, every lane count incl. clamped ones, inversions
  task automatic test_gates;
    logic [4:0] v, m, iv;
    logic       e;
    int         ne;
    for (int f = 0; f < 6; f++) begin
      for (int n = 0; n < 8; n++) begin
        for (int k = 0; k < 4; k++) begin
          for (int p = 0; p < 32; p++) begin
            iv = k[0] ? 5'h15 : 5'h00;
            set_cfg(f, n, iv, k[1]);
            block_out_in = NS'(p);
            step;
            ne = (n < 2) ? 2 : (n > 5) ? 5 : n;
            m = 5'((1 << ne) - 1);
            v = (5'(p) ^ iv) & m;
            case (f)
              0: e = (v == m);
              1: e = (v != 5'h00);
              2: e = (v != m);
              3: e = (v == 5'h00);
              4: e = ($countones(v) == 1);
              default: e = !v[0];
            endcase
            e = e ^ k[1];
            chk("gate", e, result_out);
          end
        end
      end
    end
  endtask

  // Lane0 is set, lane1 is reset
  task automatic test_latch(input int f, input logic io);
    logic [1:0] seq [8] = '{2'h1, 2'h0, 2'h2, 2'h0, 2'h3, 2'h0, 2'h1, 2'h3};
    logic       q;
    set_cfg(f, 2, 5'h00, io);
    q = 1'b0;
    for (int i = 0; i < 8; i++) begin
      block_out_in = NS'({seq[i][0], seq[i][1]});
      step;
      if (seq[i] == 2'h3)
        q = (f == 7);
      else if (seq[i] != 2'h0)
        q = seq[i][1];
      chk("latch", q ^ io, result_out);
    end
  endtask

  // Lane0 read from safe, plain and safe-output sources at index 2, wrong indices opposite or Stop
  task automatic test_src;
    logic e;
    set_cfg(1, 2, 5'h00, 1'b0);
    block_out_in = '0;
    src_idx_in[0] = NS'(2);
    for (int t = 0; t < 3; t++) begin
      for (int c = 0; c < 8; c++) begin
        src_type_in[0] = 2'(t);
        safe_in = '0;
        safe_in[2] = '{ch_a: c[0], ch_b: c[1]};
        safe_cmpl_in = c[2] ? 8'h04 : 8'hfb;
        plain_in = c[0] ? 8'h04 : 8'hfb;
        safe_out_in = plain_in;
        repeat (4) step;
        if (t == 0)
          e = c[2] ? (c[0] & !c[1]) : (c[0] & c[1]);
        else
          e = c[0];
        chk("source", e, result_out);
      end
    end
    src_type_in[0] = 2'h1;
    src_idx_in[0] = NS'(9);
    plain_in = 8'hff;
    repeat (4) step;
    chk("bad index", 1'b0, result_out);
    src_type_in[0] = 2'h3;
    src_idx_in[0] = '0;
  endtask

  task automatic test_reset;
    set_cfg(7, 2, 5'h00, 1'b0);
    block_out_in = 8'h01;
    step;
    chk("set", 1'b1, result_out);
    resetn_in = 1'b0;
    block_out_in = 8'h00;
    repeat (2) step;
    chk("in reset", 1'b0, result_out);
    resetn_in = 1'b1;
    repeat (2) step;
    chk("after reset", 1'b0, result_out);
    // Non-inverted AND: one broken wire must turn the output Off
    set_cfg(0, 5, 5'h00, 1'b0);
    block_out_in = 8'h1f;
    step;
    chk("all run", 1'b1, result_out);
    block_out_in = 8'h1b;
    step;
    chk("lost signal", 1'b0, result_out);
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    repeat (30000) @(posedge clk_in);
    err_total++;
    results();
  end

  initial begin
    err_total = 0;
    samples_checked = 0;
    resetn_in = 1'b0;
    set_cfg(0, 2, 5'h00, 1'b0);
    for (int i = 0; i < 5; i++) begin
      src_type_in[i] = 2'h3;
      src_idx_in[i] = NS'(i);
    end
    safe_in = '0;
    safe_cmpl_in = '0;
    plain_in = '0;
    safe_out_in = '0;
    block_out_in = '0;
    repeat (16) @(negedge clk_in);
    resetn_in = 1'b1;
    step;
    test_gates();
    test_latch(6, 1'b0);
    test_latch(7, 1'b0);
    test_latch(7, 1'b1);
    test_src();
    test_reset();
    results();
  end
endmodule
